/* File: design/orx_regs.v */
/*
  register bank of an eight-channel serial word receiver, reached over the
  spi port: per-channel configuration, shared fifo status, flags, word
  reads with label order mapping. the line receivers are outside; each
  channel offers received 32-bit words on rx_word/rx_valid.
  assumes spi pins asynchronous to clock; sck is oversampled (>= 8x).
*/
// How it works
// - eight 16-bit configuration registers written by opcode n4, channel in upper nibble
// - a configuration write empties that channel's receive fifo
// - opcode n5 returns the addressed channel's configuration
// - bit 0 picks rate: clear divides reference by 10, set by 80
// - bit 1 clear: flag when fifo not empty; set: flag when fifo full
// - bit 2 enables label filtering, bit 4 enables odd parity check
// - bit 3 set clears receiver and fifo and holds the channel disabled
// - bit 5 clear feeds the receiver from the self-test serial output
// - bit 6 set accepts only words whose bits 10 and 9 match compare bits
// - bit 7 is required word bit 10, bit 8 required word bit 9
// - bit 9 clear reverses the 8-bit label, set keeps received order
// - bits 15..10 ignore writes and always read zero
// - one shared 16-bit status register read by opcode 6
// - status bits 7..0 are one when fifo of receiver 8..1 is empty
// - flag-definition clear: flag high whenever fifo not empty
// - status bit 8 is receiver 1 full; flag follows it when bit 1 set
// - status bits 15..9 are full for receivers 8..2
// - label bits reordered per order bit, bits 9 to 32 pass straight
// - combined flag is the or of the eight channel flags
// - master reset clears receivers and fifos, keeps configuration
`include "orx_defs.vh"
module orx_regs #(
  parameter CHANNELS = 8,
  parameter DEPTH = 4
) (
  input wire clock,
  input wire reset,
  input wire spi_cs_n,
  input wire spi_sck,
  input wire spi_si,
  output reg spi_so,
  input wire master_reset_pin,
  input wire [CHANNELS*32-1:0] rx_word,
  input wire [CHANNELS-1:0] rx_valid,
  output reg [CHANNELS-1:0] rx_accept,
  output reg [CHANNELS-1:0] channel_fifo_flag,
  output reg flag_any,
  output reg [CHANNELS-1:0] rate_low_speed,
  output reg [CHANNELS-1:0] label_filter_enable,
  output reg [CHANNELS-1:0] parity_check_enable,
  output reg [CHANNELS-1:0] loopback_active,
  output reg [CHANNELS-1:0] receiver_clear,
  output reg master_clear
);

  localparam ST_OPCODE = 2'd0;
  localparam ST_WDATA = 2'd1;
  localparam ST_RDATA = 2'd2;
  localparam ST_IDLE = 2'd3;

  // three-stage sync; select and data changes count once stages two and three agree, sck edges as soon as they differ
  reg [2:0] cs_s_q;
  reg [2:0] sck_s_q;
  reg [2:0] si_s_q;
  reg cs_n_q;
  reg sck_q;
  reg si_q;

  reg [15:0] cfg_q [0:CHANNELS-1];
  reg [31:0] fifo_q [0:CHANNELS*DEPTH-1];
  reg [2:0] cnt_q [0:CHANNELS-1];
  reg [1:0] rd_q [0:CHANNELS-1];
  reg [1:0] wr_q [0:CHANNELS-1];

  reg [1:0] state_q;
  reg [7:0] op_q;
  reg [6:0] bitcnt_q;
  reg [31:0] shreg_q;
  reg [6:0] rd_len_q;
  reg [15:0] status_w;
  reg mr_q;
  reg cs_was_q;
  // the master reset pin is asynchronous like the spi pins
  reg [2:0] mr_s_q;
  reg mr_pin_q;
  reg [CHANNELS-1:0] pop_hit;
  reg [CHANNELS-1:0] cfg_hit;
  // one loop variable per process keeps every variable to a single driver
  integer i_st;
  integer i_hit;
  integer i_cfg;
  integer i_ff;
  integer i_acc;
  integer i_out;

  function [31:0] label_map;
    input [31:0] w;
    input keep_order;
    integer k;
    begin
      label_map = w;
      // bit 0 of w is the first received bit; reversed order swaps the label
      if (!keep_order) begin
        for (k = 0; k < 8; k = k + 1) begin
          label_map[k] = w[7-k];
        end
      end
    end
  endfunction

  function word_ok;
    input [31:0] w;
    input [15:0] c;
    begin
      word_ok = 1'b1;
      if (c[`ORX_CFG_DECODE] && (w[9] != c[`ORX_CFG_CMP10] || w[8] != c[`ORX_CFG_CMP9]))
        word_ok = 1'b0;
      if (c[`ORX_CFG_PARITY] && !(^w))
        word_ok = 1'b0;
    end
  endfunction

  wire sck_rise = sck_s_q[1] & ~sck_s_q[2] & ~cs_n_q;
  wire sck_fall = ~sck_s_q[1] & sck_s_q[2] & ~cs_n_q;
  // a frame starts only when the filtered select goes low
  wire cs_start = cs_was_q & ~cs_n_q;
  wire [3:0] op_ch = op_q[7:4] - 4'h1;
  wire op_ch_ok = (op_q[7:4] >= 4'h1) && (op_q[7:4] <= CHANNELS);
  wire [7:0] op_next = {op_q[6:0], si_q};
  wire [3:0] nch = op_next[7:4] - 4'h1;
  wire nch_ok = (op_next[7:4] >= 4'h1) && (op_next[7:4] <= CHANNELS);
  wire cfg_done = (state_q == ST_WDATA) && sck_rise && (bitcnt_q == 7'd15) &&
                  (op_q[3:0] == `ORX_OP_CFG_WRITE) && op_ch_ok;
  wire pop_start = sck_rise && (state_q == ST_OPCODE) && (bitcnt_q == 7'd7) &&
                   (op_next[3:0] == `ORX_OP_FIFO_READ) && nch_ok;

  always @* begin
    for (i_st = 0; i_st < CHANNELS; i_st = i_st + 1) begin
      status_w[i_st] = (cnt_q[i_st] == 3'd0);
      status_w[8+i_st] = (cnt_q[i_st] == DEPTH);
    end
  end

  // per-channel strobes; a read of an empty fifo leaves its pointers alone
  always @* begin
    for (i_hit = 0; i_hit < CHANNELS; i_hit = i_hit + 1) begin
      pop_hit[i_hit] = pop_start && (nch[2:0] == i_hit) && (cnt_q[i_hit] != 3'd0);
      cfg_hit[i_hit] = cfg_done && (op_ch[2:0] == i_hit);
    end
  end

  always @(posedge clock) begin
    cs_s_q <= {cs_s_q[1:0], spi_cs_n};
    sck_s_q <= {sck_s_q[1:0], spi_sck};
    si_s_q <= {si_s_q[1:0], spi_si};
    mr_s_q <= {mr_s_q[1:0], master_reset_pin};
    if (reset) begin
      cs_n_q <= 1'b1;
      cs_was_q <= 1'b1;
      sck_q <= 1'b0;
      si_q <= 1'b0;
      mr_pin_q <= 1'b0;
    end else begin
      cs_was_q <= cs_n_q;
      if (mr_s_q[1] == mr_s_q[2])
        mr_pin_q <= mr_s_q[2];
      if (cs_s_q[1] == cs_s_q[2])
        cs_n_q <= cs_s_q[2];
      if (sck_s_q[1] == sck_s_q[2])
        sck_q <= sck_s_q[2];
      if (si_s_q[1] == si_s_q[2])
        si_q <= si_s_q[2];
    end
  end

  // spi instruction engine
  always @(posedge clock) begin
    if (reset) begin
      state_q <= ST_IDLE;
      op_q <= 8'h00;
      bitcnt_q <= 7'd0;
      shreg_q <= 32'h0000_0000;
      rd_len_q <= 7'd0;
      spi_so <= 1'b0;
      mr_q <= 1'b0;
    end else begin
      mr_q <= 1'b0;
      if (cs_n_q) begin
        state_q <= ST_IDLE;
        spi_so <= 1'b0;
      end else if (cs_start) begin
        // a refused or finished instruction stays idle until the next select
        state_q <= ST_OPCODE;
        bitcnt_q <= 7'd0;
      end
      if (!cs_n_q && state_q != ST_IDLE) begin
        case (state_q)
          ST_OPCODE: begin
            if (sck_rise) begin
              op_q <= op_next;
              bitcnt_q <= bitcnt_q + 7'd1;
              if (bitcnt_q == 7'd7) begin
                bitcnt_q <= 7'd0;
                state_q <= ST_IDLE;
                case (op_next[3:0])
                  `ORX_OP_CFG_WRITE: begin
                    if (nch_ok)
                      state_q <= ST_WDATA;
                  end
                  `ORX_OP_CFG_READ: begin
                    if (nch_ok) begin
                      state_q <= ST_RDATA;
                      shreg_q <= {cfg_q[nch[2:0]] & `ORX_CFG_USED_MASK, 16'h0000};
                      rd_len_q <= 7'd16;
                    end
                  end
                  `ORX_OP_STATUS_READ: begin
                    state_q <= ST_RDATA;
                    shreg_q <= 32'h0000_0000;
                    rd_len_q <= 7'd16;
                  end
                  `ORX_OP_FIFO_READ: begin
                    if (nch_ok) begin
                      state_q <= ST_RDATA;
                      rd_len_q <= 7'd32;
                      shreg_q <= 32'h0000_0000;
                      if (cnt_q[nch[2:0]] != 3'd0)
                        shreg_q <= label_map(fifo_q[nch[2:0]*DEPTH + rd_q[nch[2:0]]],
                                             cfg_q[nch[2:0]][`ORX_CFG_ORDER]);
                    end
                  end
                  `ORX_OP_MASTER_RESET: begin
                    mr_q <= 1'b1;
                  end
                  default: begin
                    state_q <= ST_IDLE;
                  end
                endcase
              end
            end
          end
          ST_WDATA: begin
            if (sck_rise) begin
              shreg_q <= {shreg_q[30:0], si_q};
              bitcnt_q <= bitcnt_q + 7'd1;
              if (bitcnt_q == 7'd15)
                state_q <= ST_IDLE;
            end
          end
          ST_RDATA: begin
            if (sck_fall) begin
              // status bits are taken live at the moment each one leaves
              if (op_q[3:0] == `ORX_OP_STATUS_READ)
                spi_so <= status_w[4'd15 - bitcnt_q[3:0]];
              else
                spi_so <= shreg_q[31];
              if (op_q[3:0] != `ORX_OP_STATUS_READ)
                shreg_q <= {shreg_q[30:0], 1'b0};
              bitcnt_q <= bitcnt_q + 7'd1;
              if (bitcnt_q == rd_len_q)
                state_q <= ST_IDLE;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // configuration survives master reset; only the clock reset clears it
  always @(posedge clock) begin
    for (i_cfg = 0; i_cfg < CHANNELS; i_cfg = i_cfg + 1) begin
      if (reset)
        cfg_q[i_cfg] <= `ORX_CFG_RESET;
      else if (cfg_hit[i_cfg])
        cfg_q[i_cfg] <= {shreg_q[14:0], si_q} & `ORX_CFG_USED_MASK;
    end
  end

  // receive fifos
  always @(posedge clock) begin
    for (i_ff = 0; i_ff < CHANNELS; i_ff = i_ff + 1) begin
      if (reset || mr_q || mr_pin_q || cfg_q[i_ff][`ORX_CFG_CHRST] || cfg_hit[i_ff]) begin
        cnt_q[i_ff] <= 3'd0;
        rd_q[i_ff] <= 2'd0;
        wr_q[i_ff] <= 2'd0;
      end else begin
        // pointers wrap at four words; the count tells full from empty
        if (rx_accept[i_ff]) begin
          fifo_q[i_ff*DEPTH + wr_q[i_ff]] <= rx_word[i_ff*32 +: 32];
          wr_q[i_ff] <= wr_q[i_ff] + 2'd1;
        end
        if (pop_hit[i_ff])
          rd_q[i_ff] <= rd_q[i_ff] + 2'd1;
        // a push and a pop in one cycle leave the count as it is
        if (rx_accept[i_ff] && !pop_hit[i_ff])
          cnt_q[i_ff] <= cnt_q[i_ff] + 3'd1;
        else if (!rx_accept[i_ff] && pop_hit[i_ff])
          cnt_q[i_ff] <= cnt_q[i_ff] - 3'd1;
      end
    end
  end

  always @* begin
    for (i_acc = 0; i_acc < CHANNELS; i_acc = i_acc + 1) begin
      rx_accept[i_acc] = rx_valid[i_acc] && !cfg_q[i_acc][`ORX_CFG_CHRST] && !mr_pin_q &&
                         (cnt_q[i_acc] != DEPTH) &&
                         word_ok(rx_word[i_acc*32 +: 32], cfg_q[i_acc]);
    end
  end

  // control outputs and flags, registered
  always @(posedge clock) begin
    if (reset) begin
      channel_fifo_flag <= {CHANNELS{1'b0}};
      flag_any <= 1'b0;
      rate_low_speed <= {CHANNELS{1'b0}};
      label_filter_enable <= {CHANNELS{1'b0}};
      parity_check_enable <= {CHANNELS{1'b0}};
      loopback_active <= {CHANNELS{1'b0}};
      receiver_clear <= {CHANNELS{1'b1}};
      master_clear <= 1'b1;
    end else begin
      master_clear <= mr_q | mr_pin_q;
      for (i_out = 0; i_out < CHANNELS; i_out = i_out + 1) begin
        channel_fifo_flag[i_out] <= cfg_q[i_out][`ORX_CFG_FLAG] ? status_w[8+i_out] :
                                    ~status_w[i_out];
        rate_low_speed[i_out] <= cfg_q[i_out][`ORX_CFG_RATE];
        label_filter_enable[i_out] <= cfg_q[i_out][`ORX_CFG_FILTER];
        parity_check_enable[i_out] <= cfg_q[i_out][`ORX_CFG_PARITY];
        loopback_active[i_out] <= ~cfg_q[i_out][`ORX_CFG_LOOP];
        receiver_clear[i_out] <= cfg_q[i_out][`ORX_CFG_CHRST] | mr_q | mr_pin_q;
      end
      flag_any <= |channel_fifo_flag;
    end
  end

endmodule

/* File: pkg/orx_defs.vh */
/*
  constants for the octal receiver configuration/status register bank:
  spi opcodes, configuration field positions, reset values, timing counts.
  assumes inclusion by bare name from design files.
*/
`ifndef ORX_DEFS_VH
`define ORX_DEFS_VH

`define ORX_OP_LABEL_READ 4'h2
`define ORX_OP_FIFO_READ 4'h3
`define ORX_OP_CFG_WRITE 4'h4
`define ORX_OP_CFG_READ 4'h5
`define ORX_OP_STATUS_READ 4'h6
`define ORX_OP_MASTER_RESET 4'h7

`define ORX_CFG_RATE 0
`define ORX_CFG_FLAG 1
`define ORX_CFG_FILTER 2
`define ORX_CFG_CHRST 3
`define ORX_CFG_PARITY 4
`define ORX_CFG_LOOP 5
`define ORX_CFG_DECODE 6
`define ORX_CFG_CMP10 7
`define ORX_CFG_CMP9 8
`define ORX_CFG_ORDER 9
`define ORX_CFG_USED_MASK 16'h03ff
`define ORX_CFG_RESET 16'h0000

`define ORX_DIV_HIGH 10
`define ORX_DIV_LOW 80
`define ORX_OPCODE_BITS 8
`define ORX_CFG_BITS 16
`define ORX_WORD_BITS 32

`endif

/* File: verif/orx_regs_asserts.sv */
/* port checker for orx_regs, bound into every instance.
   assumes one clock domain and the synchronous active-high reset. */
module orx_regs_asserts #(
  parameter int CHANNELS = 8
) (
  input wire clock,
  input wire reset,
  input wire spi_cs_n,
  input wire spi_so,
  input wire master_reset_pin,
  input wire [CHANNELS-1:0] rx_valid,
  input wire [CHANNELS-1:0] rx_accept,
  input wire [CHANNELS-1:0] channel_fifo_flag,
  input wire flag_any,
  input wire [CHANNELS-1:0] rate_low_speed,
  input wire [CHANNELS-1:0] loopback_active,
  input wire [CHANNELS-1:0] receiver_clear,
  input wire master_clear
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  chk_flag_or: assert property (flag_any == |$past(channel_fifo_flag))
    else $error("combined flag wrong");
  chk_accept_valid: assert property ((rx_accept & ~rx_valid) == '0)
    else $error("accept without word");
  chk_mr_clear: assert property (master_reset_pin |-> ##[1:6] master_clear)
    else $error("master clear missing");
  chk_mr_rclr: assert property (master_clear |-> ##[0:2] (receiver_clear == '1))
    else $error("receivers not cleared");
  chk_mr_flags: assert property ((master_clear && rx_valid == '0)
    |-> ##[1:3] (channel_fifo_flag == '0)) else $error("flags survive master clear");
  chk_so_idle: assert property (spi_cs_n [*8] |-> !spi_so)
    else $error("data out busy while deselected");
  chk_cfg_hold: assert property (spi_cs_n [*8] |=> $stable({rate_low_speed, loopback_active}))
    else $error("config changed without write");
  chk_loop_reset: assert property ($fell(reset) |=> (loopback_active == '1))
    else $error("config not zero after reset");
endmodule

bind orx_regs orx_regs_asserts #(.CHANNELS(CHANNELS)) u_chk (.clock(clock), .reset(reset),
  .spi_cs_n(spi_cs_n), .spi_so(spi_so), .master_reset_pin(master_reset_pin),
  .rx_valid(rx_valid), .rx_accept(rx_accept), .channel_fifo_flag(channel_fifo_flag),
  .flag_any(flag_any), .rate_low_speed(rate_low_speed), .loopback_active(loopback_active),
  .receiver_clear(receiver_clear), .master_clear(master_clear));

/* File: verif/orx_spi_host.sv */
/* spi host model: one instruction per chip-select frame.
   assumes 8-clock sck phases meet the oversampling limit. */
module orx_spi_host (
  input wire clock,
  input wire spi_so,
  output reg spi_cs_n,
  output reg spi_sck,
  output reg spi_si
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_si = 1'b0;
  end
  task automatic frame(input [7:0] op, input int n, input [31:0] wd, output [31:0] rd);
    rd = 32'h0;
    spi_cs_n <= 1'b0;
    repeat (8) @(posedge clock);
    for (int i = 0; i < 8 + n; i++) begin
      spi_si <= (i < 8) ? op[7 - i] : wd[n + 7 - i];
      repeat (8) @(posedge clock);
      spi_sck <= 1'b1;
      if (i >= 8) rd = {rd[30:0], spi_so};
      repeat (8) @(posedge clock);
      spi_sck <= 1'b0;
    end
    repeat (8) @(posedge clock);
    spi_cs_n <= 1'b1;
    // deselected data line is meaningless, so keep it moving
    spi_si <= ~spi_si;
    repeat (16) @(posedge clock);
  endtask
endmodule

/* File: verif/testbench.sv */
/* self-checking bench for orx_regs with queue model of the fifos.
   assumes the spi host model drives the serial port. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 4;
  logic clock = 1'b0, reset = 1'b1, mr = 1'b0;
  logic [255:0] rx_word = '0;
  logic [7:0] rx_valid = '0;
  wire cs_n, sck, si, so, fany, mclr;
  wire [7:0] acc, flg, rate, filt, par, loopb, rclr;
  int miscompares = 0, checks_done = 0;
  logic [15:0] cfg [8];
  logic [31:0] q [8][$];
  logic [31:0] rd;
  orx_regs #(.CHANNELS(8), .DEPTH(DEPTH)) dut (.clock(clock), .reset(reset), .spi_cs_n(cs_n),
    .spi_sck(sck), .spi_si(si), .spi_so(so), .master_reset_pin(mr), .rx_word(rx_word),
    .rx_valid(rx_valid), .rx_accept(acc), .channel_fifo_flag(flg), .flag_any(fany),
    .rate_low_speed(rate), .label_filter_enable(filt), .parity_check_enable(par),
    .loopback_active(loopb), .receiver_clear(rclr), .master_clear(mclr));
  orx_spi_host host (.clock(clock), .spi_so(so), .spi_cs_n(cs_n), .spi_sck(sck), .spi_si(si));
  initial forever #25 clock = ~clock;
  task automatic cmp_reg(input [15:0] got, input [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_word(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wcfg(input int c, input [15:0] v);
    host.frame({c[3:0] + 4'h1, 4'h4}, 16, {16'h0, v}, rd);
    cfg[c] = v & 16'h03ff;
    q[c] = {};
  endtask
  task automatic chk_cfg(input int c);
    logic [15:0] f;
    f = cfg[c];
    host.frame({c[3:0] + 4'h1, 4'h5}, 16, 32'h0, rd);
    cmp_reg(rd[15:0], f);
    cmp_reg({rate[c], filt[c], par[c], loopb[c], rclr[c]}, {f[0], f[2], f[4], ~f[5], f[3]});
  endtask
  task automatic chk_stat;
    logic [15:0] s;
    logic [7:0] f;
    for (int c = 0; c < 8; c++) begin
      s[c] = q[c].size() == 0;
      s[c + 8] = q[c].size() == DEPTH;
      f[c] = cfg[c][1] ? s[c + 8] : !s[c];
    end
    host.frame(8'h06, 16, 32'h0, rd);
    cmp_reg(rd[15:0], s);
    cmp_reg({fany, flg}, {|f, f});
  endtask
  task automatic push(input int c, input [31:0] w);
    logic ok;
    ok = q[c].size() < DEPTH && !cfg[c][3] && (!cfg[c][4] || ^w)
      && (!cfg[c][6] || w[9:8] == {cfg[c][7], cfg[c][8]});
    @(posedge clock);
    rx_word[c * 32 +: 32] <= w;
    rx_valid[c] <= 1'b1;
    @(negedge clock);
    cmp_reg(acc[c], ok);
    @(posedge clock);
    rx_valid[c] <= 1'b0;
    if (ok) q[c].push_back(w);
    repeat (3) @(posedge clock);
  endtask
  task automatic pop(input int c);
    logic [31:0] e;
    e = q[c].size() ? q[c].pop_front() : 32'h0;
    if (!cfg[c][9]) e[7:0] = {e[0], e[1], e[2], e[3], e[4], e[5], e[6], e[7]};
    host.frame({c[3:0] + 4'h1, 4'h3}, 32, 32'h0, rd);
    cmp_word(rd, e);
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (8) @(posedge clock);
    void'($urandom(32'h8ab9));
    for (int c = 0; c < 8; c++) cfg[c] = 16'h0;
    chk_cfg(0);
    for (int c = 0; c < 8; c++) begin
      wcfg(c, $urandom & 16'hfff7);
      chk_cfg(c);
      repeat (DEPTH + 1) push(c, $urandom);
    end
    chk_stat();
    pop(2);
    pop(2);
    chk_stat();
    wcfg(3, 16'h0202);
    chk_stat();
    wcfg(4, 16'h0008);
    push(4, $urandom);
    chk_cfg(4);
    wcfg(4, 16'h0000);
    push(4, $urandom);
    chk_stat();
    pop(4);
    wcfg(5, 16'h02c0);
    push(5, 32'h0000_0200);
    push(5, 32'h0000_0100);
    push(5, 32'h0000_0300);
    pop(5);
    wcfg(6, 16'h0010);
    push(6, 32'h0000_0001);
    push(6, 32'h0000_0003);
    chk_stat();
    @(posedge clock);
    mr <= 1'b1;
    repeat (4) @(posedge clock);
    mr <= 1'b0;
    repeat (8) @(posedge clock);
    for (int c = 0; c < 8; c++) q[c] = {};
    chk_stat();
    for (int c = 0; c < 8; c++) chk_cfg(c);
    push(0, $urandom);
    host.frame(8'h07, 0, 32'h0, rd);
    q[0] = {};
    chk_stat();
    host.frame(8'h04, 16, 32'h0000_1234, rd);
    host.frame(8'h94, 16, 32'h0000_1234, rd);
    chk_cfg(0);
    chk_cfg(2);
    tally_and_finish();
  end
endmodule
